// file: hw/ater_pkg.sv
// Constants, field layouts and carrier types for the area translate entries.
// Function
// R1: user load allowed only when user-load permit set
// R2: user store allowed only when user-store permit set
// R3: instruction entry bits 31-10 hold frame number; translation here takes only bits 31-13 and ignores bits 12-10
// R4: entries accessible only from supervisor mode
// R5: virtual address is context id plus fetch address
// R6: entries pair with match registers for translation
// R7: bit 0 selects data cache coherency
// R8: bit 1 inhibits caching for the page
// R9: bit 2 selects write-back over write-through
// R10: bit 3 selects weak over strong ordering
// R11: bit 4 records the page was accessed
// R12: bit 5 records the page was modified
// R13: bit 6 permits supervisor instruction fetch
// R14: bit 7 permits user instruction fetch
// R15: supervisor load allowed only with supervisor-load permit
// R16: supervisor store allowed only with supervisor-store permit
// R17: refused access to matching page raises page fault
// R18: bits 9-8 reserved, ignored by translation
// R19: four instruction entries paired with same-index match
package ater_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes.
  localparam int ATER_NUM_ENT = 4;
  localparam int ATER_IDX_W = 2;
  localparam int ATER_CTX_W = 4;
  localparam int ATER_EA_W = 32;
  localparam int ATER_VA_W = 36;
  localparam int ATER_PAGE_BITS = 13;
  localparam int ATER_VPN_W = 19;

  ////////////////////////////////////////////////////////////////////////////
  // Entry field positions, shared by instruction and data entries except bits 6-9.
  localparam int ATER_COHERENT = 0;
  localparam int ATER_NOCACHE = 1;
  localparam int ATER_WRBACK = 2;
  localparam int ATER_WEAKORD = 3;
  localparam int ATER_ACC = 4;
  localparam int ATER_DIRTY = 5;
  localparam int ATER_SUP_EXEC = 6;
  localparam int ATER_USER_EXEC = 7;
  localparam int ATER_RSV_LO = 8;
  localparam int ATER_PFN_LO = 10;
  localparam int ATER_PFN_HI = 31;
  // Data entry permission positions.
  localparam int ATER_SLOAD = 6;
  localparam int ATER_SSTORE = 7;
  localparam int ATER_ULOAD = 8;
  localparam int ATER_USTORE = 9;

  // Bank select of a special-register access.
  localparam logic ATER_BANK_INSTR = 1'h0;
  localparam logic ATER_BANK_DATA = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef logic [31:0] ater_word_t;

  typedef struct packed {
    logic valid;
    logic [ATER_CTX_W-1:0] ctx;
    logic [ATER_VPN_W-1:0] vpn;
  } ater_match_s;

  typedef struct packed {
    logic valid;
    logic user;
    logic [ATER_EA_W-1:0] ea;
  } ater_fetch_s;

  typedef struct packed {
    logic valid;
    logic user;
    logic store;
    logic [ATER_EA_W-1:0] ea;
  } ater_dreq_s;

  // Ordered so that the struct equals entry bits 3..0.
  typedef struct packed {
    logic weakOrder;
    logic writeBack;
    logic noCache;
    logic coherent;
  } ater_attr_s;

  typedef struct packed {
    logic done;
    logic hit;
    logic fault;
    ater_attr_s attr;
    logic [ATER_EA_W-1:0] pa;
  } ater_xlat_s;

  typedef struct packed {
    logic write;
    logic read;
    logic bank;
    logic [ATER_IDX_W-1:0] idx;
    ater_word_t wdata;
  } ater_spr_s;

  typedef struct packed {
    logic ack;
    logic denied;
    ater_word_t rdata;
  } ater_sprrsp_s;

endpackage

// file: hw/ater_translate_regs.sv
// Area translate entries with match compare, permission check and result flops.
`timescale 1ns/1ns
module ater_translate_regs
  import ater_pkg::*;
#(
  parameter int NUM_ENT = ATER_NUM_ENT
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic supervisorMode,
  input wire logic [ATER_CTX_W-1:0] contextId,
  input wire ater_spr_s sprReq,
  output ater_sprrsp_s sprRsp,
  input wire ater_match_s [NUM_ENT-1:0] instrMatch,
  input wire ater_match_s [NUM_ENT-1:0] dataMatch,
  input wire ater_fetch_s fetchReq,
  output ater_xlat_s fetchRsp,
  input wire ater_dreq_s dataReq,
  output ater_xlat_s dataRsp
);

  ////////////////////////////////////////////////////////////////////////////
  // All state of the block in one struct.
  typedef struct packed {
    ater_word_t [NUM_ENT-1:0] iEnt;
    ater_word_t [NUM_ENT-1:0] dEnt;
    ater_sprrsp_s spr;
    ater_xlat_s fo;
    ater_xlat_s dout;
  } ater_state_s;

  ater_state_s st;
  ater_state_s next_st;

  logic [ATER_VA_W-1:0] iVa;
  logic [ATER_VA_W-1:0] dVa;
  logic [NUM_ENT-1:0] iHitVec;
  logic [NUM_ENT-1:0] dHitVec;
  logic [ATER_IDX_W-1:0] iSel;
  logic [ATER_IDX_W-1:0] dSel;
  ater_word_t iEntSel;
  ater_word_t dEntSel;
  logic iHit;
  logic dHit;
  logic iPermit;
  logic dPermit;
  logic sprOk;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by both sides.

  // One entry matches when its match register is valid and both the
  // context and the page part of the virtual address agree.
  function automatic logic entryHit(input ater_match_s m, input logic [ATER_VA_W-1:0] va);
    return m.valid && (m.ctx == va[ATER_VA_W-1:ATER_EA_W]) && (m.vpn == va[ATER_EA_W-1:ATER_PAGE_BITS]);
  endfunction

  // Lowest index wins when software has left overlapping entries.
  function automatic logic [ATER_IDX_W-1:0] firstIdx(input logic [NUM_ENT-1:0] v);
    logic [ATER_IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_ENT - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = ATER_IDX_W'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Virtual addresses: context id on top of the effective address.
  assign iVa = {contextId, fetchReq.ea}; // see R5
  assign dVa = {contextId, dataReq.ea};

  // One comparator per entry, each tied to the match register of its index.
  for (genvar g = 0; g < NUM_ENT; g++)
  begin : gMatch
    assign iHitVec[g] = entryHit(instrMatch[g], iVa); // see R6 see R19
    assign dHitVec[g] = entryHit(dataMatch[g], dVa);
  end

  // Selected entry and its permission for the present request.
  assign iSel = firstIdx(iHitVec);
  assign dSel = firstIdx(dHitVec);
  assign iEntSel = st.iEnt[iSel];
  assign dEntSel = st.dEnt[dSel];
  assign iHit = |iHitVec;
  assign dHit = |dHitVec;
  assign iPermit = fetchReq.user ? iEntSel[ATER_USER_EXEC] : iEntSel[ATER_SUP_EXEC]; // see R13 see R14
  assign sprOk = supervisorMode && (sprReq.write || sprReq.read);

  // Load and store permissions of the data entry, per privilege level.
  always_comb
  begin
    if (dataReq.user)
    begin
      dPermit = dataReq.store ? dEntSel[ATER_USTORE] : dEntSel[ATER_ULOAD]; // see R1 see R2
    end
    else
    begin
      dPermit = dataReq.store ? dEntSel[ATER_SSTORE] : dEntSel[ATER_SLOAD]; // see R15 see R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: special-register access, then translations. Hardware
  // setting of the accessed and dirty flags comes last so that it wins
  // over a software write to the same entry in the same cycle.
  always_comb
  begin
    next_st = st;
    next_st.spr = '0;
    next_st.fo = '0;
    next_st.dout = '0;

    // Move to or from an entry; user mode gets a denied answer.
    if (sprReq.write || sprReq.read)
    begin
      next_st.spr.ack = 1'h1;
      next_st.spr.denied = !supervisorMode; // see R4
      if (sprOk && sprReq.write)
      begin
        // Reserved bits are stored but never read by translation.
        if (sprReq.bank == ATER_BANK_DATA)
        begin
          next_st.dEnt[sprReq.idx] = sprReq.wdata; // see R18
        end
        else
        begin
          next_st.iEnt[sprReq.idx] = sprReq.wdata; // see R18
        end
      end
      else if (sprOk)
      begin
        next_st.spr.rdata = (sprReq.bank == ATER_BANK_DATA) ? st.dEnt[sprReq.idx] : st.iEnt[sprReq.idx];
      end
    end

    // Instruction fetch translation.
    if (fetchReq.valid)
    begin
      next_st.fo.done = 1'h1;
      next_st.fo.hit = iHit; // see R6
      next_st.fo.fault = iHit && !iPermit; // see R13 see R14 see R17
      if (iHit)
      begin
        next_st.fo.pa = {iEntSel[ATER_PFN_HI:ATER_PAGE_BITS], fetchReq.ea[ATER_PAGE_BITS-1:0]}; // see R3
        next_st.fo.attr = ater_attr_s'(iEntSel[ATER_WEAKORD:ATER_COHERENT]); // see R7 see R8 see R9 see R10
      end
      if (iHit && iPermit)
      begin
        next_st.iEnt[iSel][ATER_ACC] = 1'h1; // see R11
      end
    end

    // Data access translation.
    if (dataReq.valid)
    begin
      next_st.dout.done = 1'h1;
      next_st.dout.hit = dHit;
      next_st.dout.fault = dHit && !dPermit; // see R17
      if (dHit)
      begin
        next_st.dout.pa = {dEntSel[ATER_PFN_HI:ATER_PAGE_BITS], dataReq.ea[ATER_PAGE_BITS-1:0]};
        next_st.dout.attr = ater_attr_s'(dEntSel[ATER_WEAKORD:ATER_COHERENT]);
      end
      if (dHit && dPermit)
      begin
        next_st.dEnt[dSel][ATER_ACC] = 1'h1;
        if (dataReq.store)
        begin
          next_st.dEnt[dSel][ATER_DIRTY] = 1'h1; // see R12
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register. Entry contents are left unreset on purpose: software
  // must load them before use, and sparing the reset keeps the array cheap.
  always_ff @(posedge sys_clk)
  begin
    st <= next_st;
    if (!nrst)
    begin
      st.spr <= '0;
      st.fo <= '0;
      st.dout <= '0;
    end
  end

  // Outputs straight from the state flops.
  assign sprRsp = st.spr;
  assign fetchRsp = st.fo;
  assign dataRsp = st.dout;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // A user-mode move is answered but refused.
  a_spr_user_denied: assert property ( // see R4
    (sprReq.write || sprReq.read) && !supervisorMode |=> sprRsp.ack && sprRsp.denied && sprRsp.rdata == '0)
  else $error("user access to an entry was not denied");

  // A data entry written in supervisor mode reads back unchanged.
  a_spr_write_readback: assert property ( // see R4
    (sprOk && sprReq.write && sprReq.bank == ATER_BANK_DATA && !dataReq.valid)
    ##1 (sprOk && sprReq.read && !sprReq.write && sprReq.bank == ATER_BANK_DATA
         && sprReq.idx == $past(sprReq.idx) && !dataReq.valid)
    |=> sprRsp.rdata == $past(sprReq.wdata, 2))
  else $error("entry read back differs from the value written");

  // Every fetch is answered exactly one cycle later, and only then.
  a_fetch_answer: assert property ( // see R6
    fetchRsp.done == $past(fetchReq.valid))
  else $error("fetch answer not one cycle after request");

  // Translated address joins the frame number with the page offset.
  a_fetch_address: assert property ( // see R3
    fetchReq.valid && iHit |=> fetchRsp.hit
      && fetchRsp.pa[ATER_PAGE_BITS-1:0] == $past(fetchReq.ea[ATER_PAGE_BITS-1:0])
      && fetchRsp.pa[ATER_PFN_HI:ATER_PAGE_BITS] == $past(iEntSel[ATER_PFN_HI:ATER_PAGE_BITS]))
  else $error("fetch physical address wrong");

  // A fetch while no instruction match register is valid is a clean miss.
  a_fetch_miss: assert property ( // see R5
    fetchReq.valid && !instrMatch[0].valid && !instrMatch[1].valid
      && !instrMatch[2].valid && !instrMatch[3].valid |=> !fetchRsp.hit && !fetchRsp.fault)
  else $error("fetch hit with no valid match entry");

  // Cache and ordering attributes follow the low entry bits.
  a_fetch_attrs: assert property ( // see R7 see R8 see R9 see R10
    fetchReq.valid && iHit |=> fetchRsp.attr.coherent == $past(iEntSel[ATER_COHERENT])
      && fetchRsp.attr.noCache == $past(iEntSel[ATER_NOCACHE])
      && fetchRsp.attr.writeBack == $past(iEntSel[ATER_WRBACK])
      && fetchRsp.attr.weakOrder == $past(iEntSel[ATER_WEAKORD]))
  else $error("fetch attributes do not follow the entry");

  // User fetch faults exactly when the user execute bit is clear.
  a_user_execute: assert property ( // see R14
    fetchReq.valid && fetchReq.user && iHit |=> fetchRsp.fault == !$past(iEntSel[ATER_USER_EXEC]))
  else $error("user execute permission not applied");

  // Supervisor fetch faults exactly when the supervisor execute bit is clear.
  a_sup_execute: assert property ( // see R13
    fetchReq.valid && !fetchReq.user && iHit |=> fetchRsp.fault == !$past(iEntSel[ATER_SUP_EXEC]))
  else $error("supervisor execute permission not applied");

  // A permitted fetch marks its entry accessed.
  a_accessed_mark: assert property ( // see R11
    fetchReq.valid && iHit && iPermit |=> st.iEnt[$past(iSel)][ATER_ACC])
  else $error("accessed flag not set after fetch");

  // User loads and stores follow their permission bits.
  a_user_data: assert property ( // see R1 see R2
    dataReq.valid && dataReq.user && dHit |=> dataRsp.fault
      == ($past(dataReq.store) ? !$past(dEntSel[ATER_USTORE]) : !$past(dEntSel[ATER_ULOAD])))
  else $error("user data permission not applied");

  // Supervisor loads and stores follow their permission bits.
  a_sup_data: assert property ( // see R15 see R16
    dataReq.valid && !dataReq.user && dHit |=> dataRsp.fault
      == ($past(dataReq.store) ? !$past(dEntSel[ATER_SSTORE]) : !$past(dEntSel[ATER_SLOAD])))
  else $error("supervisor data permission not applied");

  // A fault is only ever reported for a matching page.
  a_fault_needs_hit: assert property ( // see R17
    (fetchRsp.fault |-> fetchRsp.hit && fetchRsp.done) and (dataRsp.fault |-> dataRsp.hit && dataRsp.done))
  else $error("fault without a matching entry");

  // A permitted store marks its data entry dirty.
  a_dirty_mark: assert property ( // see R12
    dataReq.valid && dataReq.store && dHit && dPermit |=> st.dEnt[$past(dSel)][ATER_DIRTY])
  else $error("dirty flag not set after store");

  // Every data access is answered exactly one cycle later, and only then.
  a_data_answer: assert property ( // see R17
    dataRsp.done == $past(dataReq.valid))
  else $error("data answer not one cycle after request");

  // Every move is answered exactly one cycle later, and only then.
  a_spr_answer: assert property ( // see R4
    sprRsp.ack == $past(sprReq.write || sprReq.read))
  else $error("move answer not one cycle after request");

  // A supervisor move is answered without refusal.
  a_spr_sup_ok: assert property ( // see R4
    sprOk |=> sprRsp.ack && !sprRsp.denied)
  else $error("supervisor move was denied");

  // A refused move leaves every entry as it was.
  a_spr_user_nowrite: assert property ( // see R4
    sprReq.write && !supervisorMode && !fetchReq.valid && !dataReq.valid
      |=> st.iEnt == $past(st.iEnt) && st.dEnt == $past(st.dEnt))
  else $error("user move changed an entry");

  // A fetch that hits no entry returns an all-zero translation.
  a_fetch_clean_miss: assert property ( // see R6
    fetchReq.valid && !iHit |=> fetchRsp.done && !fetchRsp.hit && !fetchRsp.fault
      && fetchRsp.pa == '0 && fetchRsp.attr == '0)
  else $error("fetch miss not clean");

  // A data access that hits no entry neither faults nor translates.
  a_data_clean_miss: assert property ( // see R17
    dataReq.valid && !dHit |=> dataRsp.done && !dataRsp.hit && !dataRsp.fault
      && dataRsp.pa == '0 && dataRsp.attr == '0)
  else $error("data miss not clean");

  // Reserved entry bits never reach the translated address.
  a_reserved_ignored: assert property ( // see R18
    fetchReq.valid && iHit
      |=> fetchRsp.pa[ATER_PFN_LO-1:ATER_RSV_LO] == $past(fetchReq.ea[ATER_PFN_LO-1:ATER_RSV_LO]))
  else $error("reserved entry bits reached the address");

  // Fetches never touch the dirty flag of an instruction entry.
  a_fetch_keeps_dirty: assert property ( // see R12
    fetchReq.valid && iHit && !(sprOk && sprReq.write)
      |=> st.iEnt[$past(iSel)][ATER_DIRTY] == $past(iEntSel[ATER_DIRTY]))
  else $error("fetch changed an instruction dirty flag");

  // A permitted data access marks its entry accessed.
  a_data_accessed: assert property ( // see R11
    dataReq.valid && dHit && dPermit |=> st.dEnt[$past(dSel)][ATER_ACC])
  else $error("accessed flag not set after data access");

  // A refused access leaves the dirty flag alone.
  a_refused_clean: assert property ( // see R17
    dataReq.valid && dHit && !dPermit && !(sprOk && sprReq.write)
      |=> st.dEnt[$past(dSel)][ATER_DIRTY] == $past(dEntSel[ATER_DIRTY]))
  else $error("refused access changed a dirty flag");

  // Data translation joins frame number, page offset and attributes.
  a_data_xlat: assert property ( // see R6
    dataReq.valid && dHit |=> dataRsp.hit
      && dataRsp.pa == {$past(dEntSel[ATER_PFN_HI:ATER_PAGE_BITS]), $past(dataReq.ea[ATER_PAGE_BITS-1:0])}
      && dataRsp.attr == $past(dEntSel[ATER_WEAKORD:ATER_COHERENT]))
  else $error("data translation wrong");

  // The entry of the hitting match register is the one that translates.
  a_paired_entry: assert property ( // see R19
    dataReq.valid && dHitVec[1] && !dHitVec[0]
      |=> dataRsp.pa[ATER_PFN_HI:ATER_PAGE_BITS] == $past(st.dEnt[1][ATER_PFN_HI:ATER_PAGE_BITS]))
  else $error("translation not taken from the paired entry");

endmodule

// file: verification/ater_translate_regs_test.sv
// Self-checking testbench for the area translate entry registers.
`timescale 1ns/1ns
module ater_translate_regs_test;
  import ater_pkg::*;
  localparam int LIMIT = 20000;
  logic sys_clk;
  logic nrst;
  logic supervisorMode;
  logic [ATER_CTX_W-1:0] contextId;
  ater_spr_s sprReq;
  ater_sprrsp_s sprRsp;
  ater_match_s [3:0] instrMatch;
  ater_match_s [3:0] dataMatch;
  ater_fetch_s fetchReq;
  ater_xlat_s fetchRsp;
  ater_dreq_s dataReq;
  ater_xlat_s dataRsp;
  ater_word_t shadow [2][4];
  ater_sprrsp_s sprQ[$];
  ater_xlat_s fetchQ[$];
  ater_xlat_s dataQ[$];
  logic [31:0] seed;
  int n_errors;
  int total_checks;
  int cycles;

  ater_translate_regs #(.NUM_ENT(4)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .supervisorMode(supervisorMode),
    .contextId(contextId), .sprReq(sprReq), .sprRsp(sprRsp), .instrMatch(instrMatch), .dataMatch(dataMatch),
    .fetchReq(fetchReq), .fetchRsp(fetchRsp), .dataReq(dataReq), .dataRsp(dataRsp));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, xorshift source and comparisons.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cmpSpr(input ater_sprrsp_s exp, input ater_sprrsp_s got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error sprRsp expected %h seen %h", exp, got);
    end
  endtask

  task automatic cmpXlat(input string name, input ater_xlat_s exp, input ater_xlat_s got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference translation; it also sets the shadow flags the hardware should set.
  function automatic ater_xlat_s predict(input logic bank, input logic user, input logic store, input logic [31:0] ea);
    ater_xlat_s r;
    ater_match_s m;
    ater_word_t w;
    logic perm;
    int hitIdx;
    r = '0;
    r.done = 1'b1;
    hitIdx = -1;
    // Walking downwards leaves the lowest matching index as the winner.
    for (int i = 3; i >= 0; i--)
    begin
      m = bank ? dataMatch[i] : instrMatch[i];
      if (m.valid && m.ctx == contextId && m.vpn == ea[31:13]) hitIdx = i;
    end
    if (hitIdx >= 0)
    begin
      w = shadow[bank][hitIdx];
      perm = bank ? (store ? (user ? w[9] : w[7]) : (user ? w[8] : w[6])) : (user ? w[7] : w[6]);
      r.hit = 1'b1;
      r.fault = !perm;
      r.attr = w[3:0];
      r.pa = {w[31:13], ea[12:0]};
      if (perm) shadow[bank][hitIdx][4] = 1'b1;
      if (perm && bank && store) shadow[bank][hitIdx][5] = 1'b1;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Drivers; each drives its own channel and clears the other two, so no stale request repeats.
  task automatic spr(input logic wr, input logic bank, input int idx, input ater_word_t w);
    ater_sprrsp_s e;
    e.ack = 1'b1;
    e.denied = !supervisorMode;
    e.rdata = (!wr && supervisorMode) ? shadow[bank][idx] : 32'h0;
    if (wr && supervisorMode) shadow[bank][idx] = w;
    sprReq = {wr, !wr, bank, idx[1:0], w};
    fetchReq = '0;
    dataReq = '0;
    sprQ.push_back(e);
    @(posedge sys_clk);
    #1;
  endtask

  task automatic fetch(input logic user, input logic [31:0] ea);
    fetchReq = {1'b1, user, ea};
    sprReq = '0;
    dataReq = '0;
    fetchQ.push_back(predict(1'b0, user, 1'b0, ea));
    @(posedge sys_clk);
    #1;
  endtask

  task automatic dacc(input logic user, input logic store, input logic [31:0] ea);
    dataReq = {1'b1, user, store, ea};
    sprReq = '0;
    fetchReq = '0;
    dataQ.push_back(predict(1'b1, user, store, ea));
    @(posedge sys_clk);
    #1;
  endtask

  task automatic idle();
    sprReq = '0;
    fetchReq = '0;
    dataReq = '0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic conclude();
    if (sprQ.size() + fetchQ.size() + dataQ.size() != 0)
    begin
      n_errors++;
      $display("Error responses expected %0d seen 0", sprQ.size() + fetchQ.size() + dataQ.size());
    end
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: every response pops the oldest note; an unexpected one meets a zero note.
  always @(negedge sys_clk)
  begin
    if (nrst === 1'b1 && sprRsp.ack === 1'b1) cmpSpr(sprQ.size() ? sprQ.pop_front() : '0, sprRsp);
    if (nrst === 1'b1 && fetchRsp.done === 1'b1)
      cmpXlat("fetchRsp", fetchQ.size() ? fetchQ.pop_front() : '0, fetchRsp);
    if (nrst === 1'b1 && dataRsp.done === 1'b1)
      cmpXlat("dataRsp", dataQ.size() ? dataQ.pop_front() : '0, dataRsp);
  end

  // A hang is cut off well past the fewer than 250 cycles the run needs.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [31:0] r;
    seed = 32'h494B;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    nrst = 1'b0;
    supervisorMode = 1'b1;
    contextId = 4'h5;
    sprReq = '0;
    fetchReq = '0;
    dataReq = '0;
    for (int i = 0; i < 4; i++)
    begin
      instrMatch[i] = {1'b1, 4'h5, 19'h01000 + 19'(i)};
      dataMatch[i] = {1'b1, 4'h5, 19'h02000 + 19'(i)};
    end
    // Entry 3 shadows entry 1, so the lower index has to win.
    dataMatch[3].vpn = 19'h02001;
    repeat (3) @(posedge sys_clk);
    #1;
    cmpSpr('0, sprRsp);
    cmpXlat("fetchRsp", '0, fetchRsp);
    nrst = 1'b1;
    idle();
    for (int round = 0; round < 4; round++)
    begin
      for (int k = 0; k < 8; k++) spr(1'b1, k[2], k % 4, rnd());
      for (int k = 0; k < 8; k++) spr(1'b0, k[2], k % 4, 32'h0);
      supervisorMode = 1'b0;
      spr(1'b1, 1'b0, round, rnd());
      spr(1'b0, 1'b0, round, 32'h0);
      supervisorMode = 1'b1;
      spr(1'b0, 1'b0, round, 32'h0);
      spr(1'b1, 1'b1, round, rnd());
      spr(1'b0, 1'b1, round, 32'h0);
      idle();
      for (int k = 0; k < 8; k++)
      begin
        r = rnd();
        fetch(k[0], {instrMatch[k / 2].vpn, r[12:0]});
      end
      fetch(1'b0, rnd());
      contextId = 4'hA;
      fetch(1'b0, {instrMatch[0].vpn, 13'h0123});
      contextId = 4'h5;
      for (int i = 0; i < 4; i++) instrMatch[i].valid = 1'b0;
      fetch(1'b0, {instrMatch[2].vpn, 13'h0040});
      for (int i = 0; i < 4; i++) instrMatch[i].valid = 1'b1;
      for (int k = 0; k < 16; k++)
      begin
        r = rnd();
        dacc(k[1], k[0], {dataMatch[k / 4].vpn, r[12:0]});
      end
      dacc(1'b0, 1'b0, rnd());
      idle();
      for (int k = 0; k < 8; k++) spr(1'b0, k[2], k % 4, 32'h0);
      idle();
    end
    idle();
    idle();
    conclude();
  end
endmodule
